//--- xeu_core.sv
// exception entry, mode banking, debug halt and long multiply of the core
// ---------------------------------------------------------------
// Notes on behaviour
// ---------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module xeu_core #(
  parameter logic [31:0] VEC_UNDF = 32'h00000004,
  parameter logic [31:0] VEC_TRAP = 32'h00000008,
  parameter logic [31:0] VEC_ABRT = 32'h00000010,
  parameter logic [31:0] VEC_NORM = 32'h00000018
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic fast_interrupt_request_i,
  input wire logic norm_interrupt_request_i,
  input wire logic abort_i,
  input wire logic undef_i,
  input wire logic software_trap_i,
  input wire logic boundary_i,
  input wire logic register_list_load_i,
  input wire logic breakpoint_i,
  input wire logic watchpoint_i,
  input wire logic resume_i,
  input wire logic exc_return_i,
  input wire logic [3:0] rd_idx_i,
  output logic [31:0] rd_data_o,
  input wire logic wr_en_i,
  input wire logic [3:0] wr_idx_i,
  input wire logic [31:0] wr_data_i,
  input wire logic psr_wr_i,
  input wire xeu_pkg::xeu_psr_t psr_data_i,
  input wire logic [5:0] dbg_idx_i,
  output logic [31:0] dbg_data_o,
  input wire logic [1:0] data_size_i,
  input wire logic [1:0] addr_low_i,
  output logic [3:0] byte_en_o,
  output logic fetch_half_o,
  input wire logic mul_start_i,
  input wire logic [1:0] mul_op_i,
  input wire logic [31:0] mul_a_i,
  input wire logic [31:0] mul_b_i,
  input wire logic [63:0] mul_acc_i,
  output logic [63:0] mul_res_o,
  output logic mul_done_o,
  output xeu_pkg::xeu_psr_t status_o,
  output logic entry_o,
  output logic [31:0] vector_o,
  output logic halted_o,
  output logic fast_late_o
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [4:0] phys(input logic [4:0] mode,
                                      input logic [3:0] idx);
    logic [4:0] p;
    p = {1'b0, idx};
    if (mode == xeu_pkg::MODE_FAST && idx >= xeu_pkg::IDX_FAST_LO &&
        idx != xeu_pkg::IDX_PC) begin
      p = xeu_pkg::PHYS_FAST + 5'(idx - xeu_pkg::IDX_FAST_LO);
    end else if (idx == xeu_pkg::IDX_SP || idx == xeu_pkg::IDX_LINK) begin
      unique case (mode)
        xeu_pkg::MODE_NORM: p = xeu_pkg::PHYS_NORM + 5'(idx[0] ^ 1'b1);
        xeu_pkg::MODE_SUPV: p = xeu_pkg::PHYS_SUPV + 5'(idx[0] ^ 1'b1);
        xeu_pkg::MODE_ABRT: p = xeu_pkg::PHYS_ABRT + 5'(idx[0] ^ 1'b1);
        xeu_pkg::MODE_UNDF: p = xeu_pkg::PHYS_UNDF + 5'(idx[0] ^ 1'b1);
        default: p = {1'b0, idx};
      endcase
    end
    return p;
  endfunction : phys

  // saved-status slot of a mode; user and system have none
  function automatic logic [2:0] saved_slot(input logic [4:0] mode);
    logic [2:0] s;
    unique case (mode)
      xeu_pkg::MODE_FAST: s = 3'h0;
      xeu_pkg::MODE_NORM: s = 3'h1;
      xeu_pkg::MODE_SUPV: s = 3'h2;
      xeu_pkg::MODE_ABRT: s = 3'h3;
      xeu_pkg::MODE_UNDF: s = 3'h4;
      default: s = 3'h7;
    endcase
    return s;
  endfunction : saved_slot

  function automatic logic privileged(input logic [4:0] mode);
    return mode != xeu_pkg::MODE_USER;
  endfunction : privileged

  // ---------------------------------------------------------------
  // request synchronisers
  // ---------------------------------------------------------------
  logic [1:0] fast_sync;
  logic [1:0] norm_sync;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      fast_sync <= 2'h0;
      norm_sync <= 2'h0;
    end else if (ce_i) begin
      fast_sync <= {fast_sync[0], fast_interrupt_request_i};
      norm_sync <= {norm_sync[0], norm_interrupt_request_i};
    end
  end

  // ---------------------------------------------------------------
  // exception choice
  // ---------------------------------------------------------------
  logic [31:0] gp [xeu_pkg::NUM_GP];
  xeu_pkg::xeu_psr_t saved [xeu_pkg::NUM_SAVED];
  xeu_pkg::xeu_psr_t status;
  xeu_pkg::xeu_state_t state;
  xeu_pkg::xeu_req_t req;
  xeu_pkg::xeu_req_t taken;
  logic [1:0] enter_cnt;
  logic [4:0] next_mode;
  logic [31:0] next_vec;

  // one driver for the whole word keeps the request vector a single net
  assign req = '{abort_i, fast_sync[1] && !status.fast_mask,
                 norm_sync[1] && !status.norm_mask, undef_i,
                 software_trap_i};

  // an abort is entered first; its entry masks fast, which then waits for the abort return
  always_comb begin
    next_mode = status.mode;
    next_vec = 32'h00000000;
    if (taken.abort) begin
      next_mode = xeu_pkg::MODE_ABRT;
      next_vec = VEC_ABRT;
    end else if (taken.fast) begin
      next_mode = xeu_pkg::MODE_FAST;
      next_vec = xeu_pkg::VEC_FAST;
    end else if (taken.norm) begin
      next_mode = xeu_pkg::MODE_NORM;
      next_vec = VEC_NORM;
    end else if (taken.undef) begin
      next_mode = xeu_pkg::MODE_UNDF;
      next_vec = VEC_UNDF;
    end else if (taken.trap) begin
      next_mode = xeu_pkg::MODE_SUPV;
      next_vec = VEC_TRAP;
    end
  end

  // ---------------------------------------------------------------
  // control sequence
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state <= xeu_pkg::ST_RUN;
      taken <= '0;
      enter_cnt <= 2'h0;
    end else if (ce_i) begin
      unique case (state)
        xeu_pkg::ST_RUN: begin
          if (breakpoint_i || watchpoint_i) begin
            state <= xeu_pkg::ST_HALT;
          end else if (boundary_i && req != '0) begin
            state <= xeu_pkg::ST_ENTER;
            enter_cnt <= 2'h0;
            if (req.abort) taken <= '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
            else if (req.fast) taken <= '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
            else if (req.norm) taken <= '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
            else if (req.undef) taken <= '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
            else taken <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
          end
        end
        xeu_pkg::ST_ENTER: begin
          enter_cnt <= enter_cnt + 2'h1;
          if (enter_cnt == 2'(xeu_pkg::ENTER_LEN - 1)) begin
            state <= xeu_pkg::ST_RUN;
          end
        end
        xeu_pkg::ST_HALT: begin
          if (resume_i) state <= xeu_pkg::ST_RUN;
        end
        default: state <= xeu_pkg::ST_RUN;
      endcase
    end
  end

  logic finish;
  assign finish = state == xeu_pkg::ST_ENTER &&
                  enter_cnt == 2'(xeu_pkg::ENTER_LEN - 1);

  // ---------------------------------------------------------------
  // status word and banked registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      status <= xeu_pkg::PSR_RESET;
      for (int i = 0; i < xeu_pkg::NUM_SAVED; i++) saved[i] <= '0;
    end else if (ce_i) begin
      if (finish) begin
        saved[saved_slot(next_mode)] <= status;
        status.mode <= next_mode;
        status.compressed <= 1'b0;
        status.norm_mask <= 1'b1;
        status.fast_mask <= status.fast_mask || taken.fast ||
                            taken.abort;
      end else if (exc_return_i && saved_slot(status.mode) != 3'h7) begin
        status <= saved[saved_slot(status.mode)];
      end else if (psr_wr_i) begin
        // a user program may only touch its flags, not its mode
        status <= psr_data_i;
        if (!privileged(status.mode)) begin
          status.mode <= xeu_pkg::MODE_USER;
        end else if (privileged(psr_data_i.mode)) begin
          status.compressed <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      for (int i = 0; i < xeu_pkg::NUM_GP; i++) gp[i] <= 32'h00000000;
    end else if (ce_i) begin
      if (finish) begin
        gp[phys(next_mode, xeu_pkg::IDX_LINK)] <= gp[xeu_pkg::IDX_PC];
        gp[xeu_pkg::IDX_PC] <= next_vec;
      end else if (wr_en_i && state == xeu_pkg::ST_RUN) begin
        gp[phys(status.mode, wr_idx_i)] <= wr_data_i;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rd_data_o <= 32'h00000000;
      dbg_data_o <= 32'h00000000;
    end else if (ce_i) begin
      rd_data_o <= gp[phys(status.mode, rd_idx_i)];
      // status words sit above the general registers for the debugger
      if (state != xeu_pkg::ST_HALT) dbg_data_o <= 32'h00000000;
      else if (dbg_idx_i < 6'(xeu_pkg::NUM_GP))
        dbg_data_o <= gp[dbg_idx_i[4:0]];
      else if (dbg_idx_i == 6'(xeu_pkg::NUM_GP))
        dbg_data_o <= {24'h000000, status};
      else if (dbg_idx_i < 6'(xeu_pkg::NUM_GP + 1 + xeu_pkg::NUM_SAVED))
        dbg_data_o <= {24'h000000,
                       saved[3'(dbg_idx_i - 6'(xeu_pkg::NUM_GP + 1))]};
      else dbg_data_o <= 32'h00000000;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      entry_o <= 1'b0;
      vector_o <= 32'h00000000;
    end else if (ce_i) begin
      entry_o <= finish;
      if (finish) vector_o <= next_vec;
    end
  end

  assign status_o = status;
  assign halted_o = state == xeu_pkg::ST_HALT;

  // ---------------------------------------------------------------
  // fast latency watch
  // ---------------------------------------------------------------
  // flags a wait beyond the bound; the instruction flow is outside this
  // block, so it reports rather than enforces
  logic [6:0] fast_wait;
  logic list_seen;
  logic [6:0] lat_limit;

  assign lat_limit = status.compressed ? 7'(xeu_pkg::MAX_LAT_COMPR) :
                     list_seen ? 7'(xeu_pkg::MAX_LAT_LIST) :
                     7'(xeu_pkg::MAX_LAT_PLAIN);

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      fast_wait <= 7'h00;
      list_seen <= 1'b0;
      fast_late_o <= 1'b0;
    end else if (ce_i) begin
      if (!req.fast || finish) begin
        fast_wait <= 7'h00;
        list_seen <= 1'b0;
        fast_late_o <= 1'b0;
      end else begin
        if (fast_wait != 7'h7F) fast_wait <= fast_wait + 7'h01;
        list_seen <= list_seen || register_list_load_i;
        fast_late_o <= 7'(fast_wait + 7'(xeu_pkg::SYNC_STAGES)) >=
                       lat_limit;
      end
    end
  end

  // ---------------------------------------------------------------
  // bus lanes and long multiply
  // ---------------------------------------------------------------
  always_comb begin
    unique case (data_size_i)
      xeu_pkg::SIZE_BYTE: byte_en_o = 4'h1 << addr_low_i;
      xeu_pkg::SIZE_HALF: byte_en_o = addr_low_i[1] ? 4'hC : 4'h3;
      default: byte_en_o = 4'hF;
    endcase
  end
  assign fetch_half_o = status.compressed;

  logic [63:0] prod;
  // op bit 1 selects signed operands, bit 0 adds the accumulator
  assign prod = mul_op_i[1] ?
                64'($signed(mul_a_i) * $signed(mul_b_i)) :
                64'(mul_a_i * mul_b_i);

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      mul_res_o <= 64'h0000000000000000;
      mul_done_o <= 1'b0;
    end else if (ce_i) begin
      mul_done_o <= mul_start_i;
      if (mul_start_i) begin
        mul_res_o <= prod + (mul_op_i[0] ? mul_acc_i :
                             64'h0000000000000000);
      end
    end
  end

endmodule : xeu_core
`default_nettype wire

//--- xeu_pkg.sv
// shared constants and types for the exception entry unit
package xeu_pkg;

  // ---------------------------------------------------------------
  // mode codes and status word layout
  // ---------------------------------------------------------------
  localparam logic [4:0] MODE_USER = 5'h10;
  localparam logic [4:0] MODE_FAST = 5'h11;
  localparam logic [4:0] MODE_NORM = 5'h12;
  localparam logic [4:0] MODE_SUPV = 5'h13;
  localparam logic [4:0] MODE_ABRT = 5'h17;
  localparam logic [4:0] MODE_UNDF = 5'h1B;
  localparam logic [4:0] MODE_SYST = 5'h1F;

  typedef struct packed {
    logic       norm_mask;
    logic       fast_mask;
    logic       compressed;
    logic [4:0] mode;
  } xeu_psr_t;

  localparam xeu_psr_t PSR_RESET = '{1'b1, 1'b1, 1'b0, MODE_SUPV};

  typedef struct packed {
    logic abort;
    logic fast;
    logic norm;
    logic undef;
    logic trap;
  } xeu_req_t;

  // ---------------------------------------------------------------
  // register file geometry
  // ---------------------------------------------------------------
  localparam int NUM_GP = 31;
  localparam int NUM_SAVED = 5;
  localparam logic [3:0] IDX_FAST_LO = 4'h8;
  localparam logic [3:0] IDX_SP = 4'hD;
  localparam logic [3:0] IDX_LINK = 4'hE;
  localparam logic [3:0] IDX_PC = 4'hF;
  localparam logic [4:0] PHYS_FAST = 5'h10;
  localparam logic [4:0] PHYS_NORM = 5'h17;
  localparam logic [4:0] PHYS_SUPV = 5'h19;
  localparam logic [4:0] PHYS_ABRT = 5'h1B;
  localparam logic [4:0] PHYS_UNDF = 5'h1D;

  // ---------------------------------------------------------------
  // vectors and timing
  // ---------------------------------------------------------------
  localparam logic [31:0] VEC_FAST = 32'h0000001C;
  localparam int SYNC_STAGES = 2;
  localparam int MIN_LATENCY = 5;
  localparam int ENTER_LEN = MIN_LATENCY - SYNC_STAGES - 1;
  localparam int MAX_LAT_LIST = 50;
  localparam int MAX_LAT_PLAIN = 42;
  localparam int MAX_LAT_COMPR = 22;

  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_ENTER = 3'b010,
    ST_HALT = 3'b100
  } xeu_state_t;

  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

endpackage : xeu_pkg

//--- xeu_core_asserts.sv
// port-level checker for the exception entry unit
`timescale 1ns/1ps
`default_nettype none
module xeu_chk (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic fast_interrupt_request_i,
  input wire logic breakpoint_i,
  input wire logic watchpoint_i,
  input wire logic mul_start_i,
  input wire logic [1:0] mul_op_i,
  input wire logic [31:0] mul_a_i,
  input wire logic [31:0] mul_b_i,
  input wire logic [63:0] mul_res_o,
  input wire logic mul_done_o,
  input wire logic [1:0] data_size_i,
  input wire logic [3:0] byte_en_o,
  input wire logic fetch_half_o,
  input wire xeu_pkg::xeu_psr_t status_o,
  input wire logic entry_o,
  input wire logic [31:0] vector_o,
  input wire logic halted_o,
  input wire logic [31:0] dbg_data_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  // ---------------------------------------------------------------
  // entry steps
  // ---------------------------------------------------------------
  sequence s_fast_in;
    entry_o && status_o.mode == xeu_pkg::MODE_FAST;
  endsequence
  sequence s_quiet2;
    !entry_o ##1 !entry_o;
  endsequence
  AST_FAST_VEC: assert property (
    s_fast_in |-> vector_o == xeu_pkg::VEC_FAST)
    else $error("fast entry vector wrong");
  AST_MIN_LAT: assert property (
    s_fast_in |-> $past(fast_interrupt_request_i, 5))
    else $error("fast entry sooner than five cycles");
  AST_ENTRY_ONE: assert property (
    entry_o |=> s_quiet2)
    else $error("entry pulse too long");
  AST_ENTRY_MASK: assert property (
    entry_o |-> status_o.norm_mask && status_o.mode != xeu_pkg::MODE_USER)
    else $error("entry left user mode or unmasked");
  AST_PRIV_FULL: assert property (
    status_o.mode != xeu_pkg::MODE_USER |-> !status_o.compressed)
    else $error("privileged mode in compressed state");
  AST_FETCH_HALF: assert property (
    fetch_half_o == status_o.compressed)
    else $error("fetch width disagrees with state");
  AST_WORD_LANES: assert property (
    data_size_i == xeu_pkg::SIZE_WORD |-> byte_en_o == 4'hF)
    else $error("word transfer lanes wrong");
  // ---------------------------------------------------------------
  // multiply and debug
  // ---------------------------------------------------------------
  AST_MUL_DONE: assert property (
    mul_start_i |=> mul_done_o)
    else $error("multiply done missing");
  AST_MUL_UNS: assert property (
    mul_start_i && mul_op_i == 2'h0 |=>
    mul_res_o == {32'h0, $past(mul_a_i)} * {32'h0, $past(mul_b_i)})
    else $error("unsigned product wrong");
  AST_HALT_CAUSE: assert property (
    $rose(halted_o) |-> $past(breakpoint_i || watchpoint_i))
    else $error("halt without break or watch");
  AST_DBG_HIDDEN: assert property (
    !halted_o && !$past(halted_o) |-> dbg_data_o == 32'h0)
    else $error("debug data visible while running");
endmodule : xeu_chk
`default_nettype wire

//--- xeu_irq_src.sv
// interrupt source model driving the two request lines
`timescale 1ns/1ps
`default_nettype none
module xeu_irq_src (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic set_fast_i,
  input wire logic set_norm_i,
  input wire logic entry_i,
  input wire logic [4:0] mode_i,
  output logic fast_o,
  output logic norm_o
);
  // a source holds its level until its own handler is entered;
  // dropping it sooner would hide a lost request
  always_ff @(posedge mclk_i) begin
    if (rst_i || (entry_i && mode_i == xeu_pkg::MODE_FAST)) begin
      fast_o <= 1'b0;
    end else if (set_fast_i) begin
      fast_o <= 1'b1;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (rst_i || (entry_i && mode_i == xeu_pkg::MODE_NORM)) begin
      norm_o <= 1'b0;
    end else if (set_norm_i) begin
      norm_o <= 1'b1;
    end
  end
endmodule : xeu_irq_src
`default_nettype wire

//--- xeu_core_tb.sv
// self-checking bench for the exception entry unit
`timescale 1ns/1ps
`default_nettype none
module xeu_core_tb;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic set_fast, set_norm, fast_req, norm_req, abort_i, undef_i, trap_i;
  logic boundary_i, brk_i, wch_i, resume_i, ret_i, wr_en_i, psr_wr_i;
  logic ce_i, list_i;
  logic mul_start_i, mul_done_o, entry_o, fetch_half_o, halted_o, late_o;
  logic [3:0] rd_idx_i, wr_idx_i, byte_en_o;
  logic [5:0] dbg_idx_i;
  logic [1:0] mul_op_i, size_i, addr_i;
  logic [31:0] rd_data_o, wr_data_i, dbg_data_o, vector_o, mul_a_i, mul_b_i;
  logic [63:0] mul_acc_i, mul_res_o;
  xeu_pkg::xeu_psr_t psr_data_i, status_o;
  int failures = 0;
  int total_checks = 0;
  int cyc = 0;

  always #5 mclk_i = ~mclk_i;

  xeu_irq_src src (.mclk_i(mclk_i), .rst_i(rst_i), .set_fast_i(set_fast),
    .set_norm_i(set_norm), .entry_i(entry_o), .mode_i(status_o.mode),
    .fast_o(fast_req), .norm_o(norm_req));

  xeu_core uut (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i),
    .fast_interrupt_request_i(fast_req), .norm_interrupt_request_i(norm_req),
    .abort_i(abort_i), .undef_i(undef_i), .software_trap_i(trap_i),
    .boundary_i(boundary_i), .register_list_load_i(list_i),
    .breakpoint_i(brk_i), .watchpoint_i(wch_i), .resume_i(resume_i),
    .exc_return_i(ret_i), .rd_idx_i(rd_idx_i), .rd_data_o(rd_data_o),
    .wr_en_i(wr_en_i), .wr_idx_i(wr_idx_i), .wr_data_i(wr_data_i),
    .psr_wr_i(psr_wr_i), .psr_data_i(psr_data_i), .dbg_idx_i(dbg_idx_i),
    .dbg_data_o(dbg_data_o), .data_size_i(size_i),
    .addr_low_i(addr_i), .byte_en_o(byte_en_o), .fetch_half_o(fetch_half_o),
    .mul_start_i(mul_start_i), .mul_op_i(mul_op_i), .mul_a_i(mul_a_i),
    .mul_b_i(mul_b_i), .mul_acc_i(mul_acc_i), .mul_res_o(mul_res_o),
    .mul_done_o(mul_done_o), .status_o(status_o), .entry_o(entry_o),
    .vector_o(vector_o), .halted_o(halted_o), .fast_late_o(late_o));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic tick(input int n = 1);
    repeat (n) @(negedge mclk_i);
  endtask : tick

  task automatic wreg(input logic [3:0] i, input logic [31:0] d);
    wr_idx_i = i;
    wr_data_i = d;
    wr_en_i = 1'b1;
    tick();
    wr_en_i = 1'b0;
    tick();
  endtask : wreg

  task automatic rd(input logic [3:0] i);
    rd_idx_i = i;
    tick();
  endtask : rd

  task automatic wpsr(input logic [7:0] v);
    psr_data_i = v;
    psr_wr_i = 1'b1;
    tick();
    psr_wr_i = 1'b0;
    tick();
  endtask : wpsr

  task automatic ret;
    // a source cleared at entry must drain out of the synchroniser first,
    // or its stale level is taken again once the mask drops
    tick(3);
    ret_i = 1'b1;
    tick();
    ret_i = 1'b0;
    tick();
  endtask : ret

  // bounded wait; n counts falling edges until the entry pulse
  task automatic wait_entry(output int n);
    n = 0;
    while (entry_o !== 1'b1 && n < xeu_pkg::MAX_LAT_LIST) begin
      tick();
      n++;
    end
    chk(entry_o, 1'b1);
  endtask : wait_entry

  task automatic raise(input logic f, input logic nm);
    set_fast = f;
    set_norm = nm;
    tick();
    set_fast = 1'b0;
    set_norm = 1'b0;
  endtask : raise

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_bank;
    int n;
    chk(status_o, xeu_pkg::PSR_RESET);
    wpsr(8'h10);
    wreg(4'h8, 32'hA8);
    wreg(4'hD, 32'hAD);
    wreg(4'hF, 32'h100);
    wpsr(8'h30);
    chk(fetch_half_o, 1'b1);
    raise(1'b1, 1'b0);
    wait_entry(n);
    chk(n, 5);
    chk(vector_o, xeu_pkg::VEC_FAST);
    chk(status_o, 8'hD1);
    rd(4'h8);
    chk(rd_data_o, 32'h0);
    rd(4'hD);
    chk(rd_data_o, 32'h0);
    rd(4'hE);
    chk(rd_data_o, 32'h100);
    rd(4'hF);
    chk(rd_data_o, xeu_pkg::VEC_FAST);
    ret();
    chk(status_o, 8'h30);
    rd(4'h8);
    chk(rd_data_o, 32'hA8);
    rd(4'hD);
    chk(rd_data_o, 32'hAD);
    $display("test bank done");
  endtask : t_bank

  task automatic t_prio;
    int n;
    raise(1'b1, 1'b1);
    wait_entry(n);
    chk(status_o.mode, xeu_pkg::MODE_FAST);
    n = 0;
    repeat (30) begin
      tick();
      if (entry_o !== 1'b0) n++;
    end
    chk(n, 0);
    ret();
    wait_entry(n);
    chk(status_o.mode, xeu_pkg::MODE_NORM);
    chk(vector_o, 32'h18);
    ret();
    $display("test priority done");
  endtask : t_prio

  // each bound in turn, end points exact: list load seen, plain, compressed
  task automatic t_late;
    int n;
    int lim [3] = '{xeu_pkg::MAX_LAT_LIST, xeu_pkg::MAX_LAT_PLAIN,
      xeu_pkg::MAX_LAT_COMPR};
    for (int k = 0; k < 3; k++) begin
      wpsr(k == 2 ? 8'h30 : 8'h10);
      boundary_i = 1'b0;
      list_i = (k == 0);
      raise(1'b1, 1'b0);
      tick(lim[k]);
      chk(late_o, 1'b0);
      tick();
      chk(late_o, 1'b1);
      list_i = 1'b0;
      boundary_i = 1'b1;
      wait_entry(n);
      chk(status_o.mode, xeu_pkg::MODE_FAST);
      ret();
    end
    $display("test latency done");
  endtask : t_late

  // all three raised at first, then fewer: checks the order too
  task automatic t_sync;
    int n;
    logic [4:0] md [3] = '{xeu_pkg::MODE_ABRT, xeu_pkg::MODE_UNDF,
      xeu_pkg::MODE_SUPV};
    logic [31:0] vec [3] = '{32'h10, 32'h04, 32'h08};
    for (int k = 0; k < 3; k++) begin
      {abort_i, undef_i, trap_i} = 3'b111 >> k;
      tick();
      {abort_i, undef_i, trap_i} = 3'b000;
      wait_entry(n);
      chk(status_o.mode, md[k]);
      chk(vector_o, vec[k]);
      ret();
    end
    $display("test sync done");
  endtask : t_sync

  task automatic t_mul;
    logic [63:0] e;
    mul_a_i = 32'hFFFFFFFE;
    mul_b_i = 32'h3;
    mul_acc_i = 64'h10;
    for (int k = 0; k < 4; k++) begin
      mul_op_i = k[1:0];
      mul_start_i = 1'b1;
      e = k[1] ? {{32{mul_a_i[31]}}, mul_a_i} * {{32{mul_b_i[31]}}, mul_b_i}
        : {32'h0, mul_a_i} * {32'h0, mul_b_i};
      e = e + (k[0] ? mul_acc_i : 64'h0);
      tick();
      chk(mul_done_o, 1'b1);
      chk(mul_res_o, e);
    end
    // with the enable low a new start must leave the result frozen
    mul_a_i = 32'h7;
    ce_i = 1'b0;
    tick();
    chk(mul_res_o, e);
    ce_i = 1'b1;
    mul_start_i = 1'b0;
    tick();
    $display("test multiply done");
  endtask : t_mul

  task automatic t_halt;
    wreg(4'h0, 32'h5A);
    for (int k = 0; k < 2; k++) begin
      {brk_i, wch_i} = k[0] ? 2'b01 : 2'b10;
      tick();
      {brk_i, wch_i} = 2'b00;
      chk(halted_o, 1'b1);
      dbg_idx_i = 6'h0;
      tick();
      chk(dbg_data_o, 32'h5A);
      dbg_idx_i = 6'h1F;
      tick();
      chk(dbg_data_o, 32'h30);
      resume_i = 1'b1;
      tick();
      resume_i = 1'b0;
      chk(halted_o, 1'b0);
      tick();
    end
    $display("test halt done");
  endtask : t_halt

  task automatic t_lanes;
    logic [3:0] eb [4] = '{4'h1, 4'h2, 4'h4, 4'h8};
    logic [3:0] eh [4] = '{4'h3, 4'h3, 4'hC, 4'hC};
    for (int k = 0; k < 4; k++) begin
      addr_i = k[1:0];
      size_i = xeu_pkg::SIZE_BYTE;
      tick();
      chk(byte_en_o, eb[k]);
      size_i = xeu_pkg::SIZE_HALF;
      tick();
      chk(byte_en_o, eh[k]);
      size_i = xeu_pkg::SIZE_WORD;
      tick();
      chk(byte_en_o, 4'hF);
    end
    $display("test lanes done");
  endtask : t_lanes

  // ---------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      close_out();
    end
  end

  initial begin
    {set_fast, set_norm, abort_i, undef_i, trap_i, brk_i, wch_i} = '0;
    {resume_i, ret_i, wr_en_i, psr_wr_i, mul_start_i, mul_op_i} = '0;
    {rd_idx_i, wr_idx_i, dbg_idx_i, wr_data_i, psr_data_i} = '0;
    {mul_a_i, mul_b_i, mul_acc_i} = '0;
    {list_i, addr_i} = '0;
    size_i = xeu_pkg::SIZE_WORD;
    ce_i = 1'b1;
    boundary_i = 1'b1;
    tick(6);
    rst_i = 1'b0;
    tick();
    t_bank();
    t_prio();
    t_late();
    t_sync();
    t_mul();
    t_halt();
    t_lanes();
    close_out();
  end
endmodule : xeu_core_tb

bind xeu_core xeu_chk u_chk (.mclk_i(mclk_i), .rst_i(rst_i),
  .fast_interrupt_request_i(fast_interrupt_request_i),
  .breakpoint_i(breakpoint_i), .watchpoint_i(watchpoint_i),
  .mul_start_i(mul_start_i), .mul_op_i(mul_op_i), .mul_a_i(mul_a_i),
  .mul_b_i(mul_b_i), .mul_res_o(mul_res_o), .mul_done_o(mul_done_o),
  .data_size_i(data_size_i), .byte_en_o(byte_en_o),
  .fetch_half_o(fetch_half_o), .status_o(status_o), .entry_o(entry_o),
  .vector_o(vector_o), .halted_o(halted_o), .dbg_data_o(dbg_data_o));
`default_nettype wire
